// *** design/thl_trip_logger.sv ***
// trip history logger top: trip log, output-stage disable, monitor freeze,
// log clear command and firmware programming error code
// assumes all inputs synchronous to I_MCLK; trip request is a one-cycle pulse
//
// Contract
// - keep ten newest trip codes, slot 0 newest, slot 9 oldest
// - new trip enters slot 0, older entries shift down, oldest dropped
// - store date and time stamp with each trip, shifting alongside
// - parallel sub-code log, zero when trip has no sub-code
// - serial read of a log slot returns its numeric trip code
// - writing 255 to log-clear parameter resets all trip logs
// - any trip disables the power output stage at once
// - monitor values freeze at trip-time contents until trip cleared
// - config bit 4 set disables monitor freezing
// - programming error 1 memory overrun, error 2 missing reset ack
// - programming error 3 flash erase fail, error 4 flash program fail
// - module missing init-done flag gives programming error 5
`include "thl_map.svh"
`default_nettype none

module thl_trip_logger #(
  parameter int DEPTH = `THL_LOG_DEPTH,
  parameter int MON_N = `THL_MON_N,
  parameter int MON_W = `THL_MON_W,
  parameter int OPT_N = 4
) (
  input wire logic I_MCLK,                                  // 50 MHz clock
  input wire logic I_RST_N,                                 // async reset, low
  input wire logic i_trip,                                  // trip event pulse
  input wire logic [`THL_CODE_W-1:0] i_trip_code,           // trip number
  input wire logic i_trip_has_sub,                          // sub-code valid
  input wire logic [`THL_SUB_W-1:0] i_trip_sub,             // sub-trip number
  input wire logic i_trip_clear,                            // trip reset pulse
  input wire logic [`THL_DATE_W-1:0] i_date,                // calendar date
  input wire logic [`THL_TIME_W-1:0] i_time,                // time of day
  input wire logic [7:0] i_trip_cfg,                        // trip action config
  input wire logic i_clr_wr,                                // log-clear write strobe
  input wire logic [7:0] i_clr_data,                        // log-clear write value
  input wire logic i_rd,                                    // serial read strobe
  input wire logic [3:0] i_rd_idx,                          // log slot to read
  input wire logic [MON_N*MON_W-1:0] i_mon,                 // live monitor values
  input wire logic i_prog_active,                           // firmware programming
  input wire thl_pkg::thl_prog_type i_prog_flt,             // programming faults
  input wire logic [OPT_N-1:0] i_module_init_done_flag,     // option init done
  input wire logic [OPT_N-1:0] i_opt_present,               // option fitted
  input wire logic i_init_check,                            // sample init flags
  output logic O_STAGE_EN,                                  // power stage enable
  output logic O_TRIPPED,                                   // tripped state
  output logic O_FROZEN,                                    // monitors frozen
  output logic [MON_N*MON_W-1:0] O_MON,                     // monitor values
  output logic O_RD_VALID,                                  // read answer valid
  output logic [`THL_CODE_W-1:0] O_RD_CODE,                 // read trip code
  output logic [`THL_SUB_W-1:0] O_RD_SUB,                   // read sub-code
  output logic [`THL_DATE_W-1:0] O_RD_DATE,                 // read date stamp
  output logic [`THL_TIME_W-1:0] O_RD_TIME,                 // read time stamp
  output logic [2:0] O_PROG_ERR                             // programming error code
);

  logic tripped_reg;
  logic frozen_reg;
  logic rd_pend_reg;
  logic log_clear;
  logic freeze_en;
  thl_pkg::thl_entry_type new_entry;
  thl_pkg::thl_entry_type rd_entry;
  logic [2:0] prog_err_next;
  logic [OPT_N-1:0] init_miss;

  ////////////////////////////////////////////////////////////////////////
  // decode helpers; the freeze and trip terms feed a flag and its output
  // copy alike, so one definition keeps the two from drifting apart

  // a trip freezes the monitors only while freezing is enabled
  function automatic logic freeze_take(
    input logic trip,
    input logic en
  );
    return trip && en;
  endfunction : freeze_take

  // a trip clear, or freezing switched off, lets the monitors run again
  function automatic logic freeze_drop(
    input logic clear,
    input logic en
  );
    return clear || !en;
  endfunction : freeze_drop

  // hold register follows its input unless a freeze is in force
  function automatic logic mon_live(
    input logic frozen,
    input logic en
  );
    return !frozen || !en;
  endfunction : mon_live

  // only the one key value wipes the history; any other write is ignored
  function automatic logic clear_hit(
    input logic wr,
    input logic [7:0] data
  );
    return wr && (data == `THL_CLEAR_KEY);
  endfunction : clear_hit

  // tripped next state; a trip in the clear cycle wins so none is lost
  function automatic logic trip_next(
    input logic cur,
    input logic trip,
    input logic clear
  );
    logic nxt;
    nxt = cur;
    if (trip) begin
      nxt = 1'b1;
    end else if (clear) begin
      nxt = 1'b0;
    end
    return nxt;
  endfunction : trip_next

  // one log entry from the trip-time inputs; no sub-code stores zero
  function automatic thl_pkg::thl_entry_type make_entry(
    input logic [`THL_CODE_W-1:0] code,
    input logic has_sub,
    input logic [`THL_SUB_W-1:0] sub,
    input logic [`THL_DATE_W-1:0] date,
    input logic [`THL_TIME_W-1:0] tod
  );
    thl_pkg::thl_entry_type ent;
    ent.code = code;
    ent.sub = has_sub ? sub : '0;
    ent.date = date;
    ent.tod = tod;
    return ent;
  endfunction : make_entry

  // programming error priority: the lowest code wins when several stand
  function automatic logic [2:0] err_pick(
    input thl_pkg::thl_prog_type flt,
    input logic init_bad
  );
    logic [2:0] code;
    code = `THL_ERR_NONE;
    if (flt.mem_over) begin
      code = `THL_ERR_MEM;
    end else if (flt.ack_miss) begin
      code = `THL_ERR_ACK;
    end else if (flt.erase_fail) begin
      code = `THL_ERR_ERASE;
    end else if (flt.prog_fail) begin
      code = `THL_ERR_PROG;
    end else if (init_bad) begin
      code = `THL_ERR_INIT;
    end
    return code;
  endfunction : err_pick

  ////////////////////////////////////////////////////////////////////////
  // trip entry assembly and log clear decode
  // a clear write in a trip cycle wipes the log, that trip's entry too;
  // the trip still drops the stage, so only its history line is lost
  assign log_clear = clear_hit(i_clr_wr, i_clr_data);
  assign freeze_en = !i_trip_cfg[`THL_CFG_NOFREEZE_BIT];
  assign new_entry = make_entry(i_trip_code, i_trip_has_sub, i_trip_sub,
    i_date, i_time);

  // history store; shift on trip in the trip cycle itself
  // slots 10 to 15 do not exist, a read of them answers zero
  thl_log_mem #(
    .DEPTH(DEPTH)
  ) u_log (
    .i_clk(I_MCLK),
    .i_rst_n(I_RST_N),
    .i_shift(i_trip),
    .i_clear(log_clear),
    .i_entry(new_entry),
    .i_rd_idx(i_rd_idx),
    .o_rd_entry(rd_entry)
  );

  ////////////////////////////////////////////////////////////////////////
  // trip state; a trip in the clear cycle wins so it is never lost
  // walk: trip taken at edge n, stage off and tripped shown after edge n;
  // clear taken at edge m, stage back on after edge m
  always_ff @(posedge I_MCLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      tripped_reg <= 1'b0;
    end else begin
      tripped_reg <= trip_next(tripped_reg, i_trip, i_trip_clear);
    end
  end

  // output stage drops in the same edge as the trip is taken
  always_ff @(posedge I_MCLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_STAGE_EN <= 1'b0;
    end else if (i_trip) begin
      O_STAGE_EN <= 1'b0;
    end else begin
      O_STAGE_EN <= !tripped_reg || i_trip_clear;
    end
  end

  always_ff @(posedge I_MCLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_TRIPPED <= 1'b0;
    end else begin
      O_TRIPPED <= trip_next(O_TRIPPED, i_trip, i_trip_clear);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // monitor freeze: the trip-cycle sample is the last one captured
  // walk: trip at edge n captures i_mon once more and sets the freeze;
  // clear at edge m drops it, and the first fresh sample lands at m + 1
  always_ff @(posedge I_MCLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      frozen_reg <= 1'b0;
    end else if (freeze_take(i_trip, freeze_en)) begin
      frozen_reg <= 1'b1;
    end else if (freeze_drop(i_trip_clear, freeze_en)) begin
      frozen_reg <= 1'b0;
    end
  end

  always_ff @(posedge I_MCLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_FROZEN <= 1'b0;
    end else if (freeze_take(i_trip, freeze_en)) begin
      O_FROZEN <= 1'b1;
    end else if (freeze_drop(i_trip_clear, freeze_en)) begin
      O_FROZEN <= 1'b0;
    end
  end

  // held values track live input until a freeze; bit 4 keeps them live
  // so a diagnostic snapshot is traded for live values while it is set
  always_ff @(posedge I_MCLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_MON <= '0;
    end else if (mon_live(frozen_reg, freeze_en)) begin
      O_MON <= i_mon;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // serial read: memory read is registered, so answer lands two edges later
  always_ff @(posedge I_MCLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      rd_pend_reg <= 1'b0;
    end else begin
      rd_pend_reg <= i_rd;
    end
  end

  // walk: strobe and slot taken at edge n, slot copied out at edge n,
  // answer strobe and data set at edge n + 1, seen by the host at n + 2;
  // back to back strobes are fine, each answer strobe stands one cycle
  always_ff @(posedge I_MCLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_RD_VALID <= 1'b0;
    end else begin
      O_RD_VALID <= rd_pend_reg;
    end
  end

  // answer data stands until the next read replaces it
  always_ff @(posedge I_MCLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_RD_CODE <= '0;
      O_RD_SUB <= '0;
      O_RD_DATE <= '0;
      O_RD_TIME <= '0;
    end else if (rd_pend_reg) begin
      O_RD_CODE <= rd_entry.code;
      O_RD_SUB <= rd_entry.sub;
      O_RD_DATE <= rd_entry.date;
      O_RD_TIME <= rd_entry.tod;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // programming error priority: lowest code first, first error sticks
  // option flags are only judged while the init check is asked for, so a
  // module that is still starting up is not blamed before its time
  assign init_miss = i_opt_present & ~i_module_init_done_flag;

  // an absent slot never counts, whatever its flag line shows
  always_comb begin
    prog_err_next = err_pick(i_prog_flt, i_init_check && (|init_miss));
  end

  // cleared only by reset, as a power cycle is the documented cure
  always_ff @(posedge I_MCLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_PROG_ERR <= `THL_ERR_NONE;
    end else if (i_prog_active && (O_PROG_ERR == `THL_ERR_NONE)) begin
      O_PROG_ERR <= prog_err_next;
    end
  end

endmodule : thl_trip_logger

`default_nettype wire

// *** design/thl_map.svh ***
// trip history logger: field widths, clear key, config bit position, error codes and counts
// assumes inclusion by bare name from the package and design files
`ifndef THL_MAP_SVH
`define THL_MAP_SVH

`define THL_LOG_DEPTH 10
`define THL_CODE_W 8
`define THL_SUB_W 8
`define THL_DATE_W 16
`define THL_TIME_W 16
`define THL_MON_W 16
`define THL_MON_N 18
`define THL_CLEAR_KEY 8'hff
`define THL_CFG_NOFREEZE_BIT 4
`define THL_ERR_NONE 3'h0
`define THL_ERR_MEM 3'h1
`define THL_ERR_ACK 3'h2
`define THL_ERR_ERASE 3'h3
`define THL_ERR_PROG 3'h4
`define THL_ERR_INIT 3'h5

`endif

// *** design/thl_pkg.sv ***
// trip history logger: shared types
// assumes thl_map.svh on the include path
`include "thl_map.svh"
`default_nettype none

package thl_pkg;
  // one log entry as it is stored and shifted
  typedef struct packed {
    logic [`THL_CODE_W-1:0] code;
    logic [`THL_SUB_W-1:0] sub;
    logic [`THL_DATE_W-1:0] date;
    logic [`THL_TIME_W-1:0] tod;
  } thl_entry_type;

  // programming fault inputs
  typedef struct packed {
    logic mem_over;
    logic ack_miss;
    logic erase_fail;
    logic prog_fail;
  } thl_prog_type;
endpackage : thl_pkg

`default_nettype wire

// *** design/thl_log_mem.sv ***
// trip history logger: ten-deep shifting entry store with registered read
// assumes one clock, async active-low reset, shift and clear never both needed
`include "thl_map.svh"
`default_nettype none

module thl_log_mem #(
  parameter int DEPTH = `THL_LOG_DEPTH
) (
  input wire logic i_clk,                          // system clock
  input wire logic i_rst_n,                        // async reset, low
  input wire logic i_shift,                        // push new entry at slot 0
  input wire logic i_clear,                        // wipe all slots
  input wire thl_pkg::thl_entry_type i_entry,      // entry to push
  input wire logic [3:0] i_rd_idx,                 // slot to read
  output thl_pkg::thl_entry_type o_rd_entry        // registered read data
);

  thl_pkg::thl_entry_type slot_reg [DEPTH];

  ////////////////////////////////////////////////////////////////////////
  // shift register store; clear wins so a wipe is never half-done
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        slot_reg[i] <= '0;
      end
    end else if (i_clear) begin
      for (int i = 0; i < DEPTH; i++) begin
        slot_reg[i] <= '0;
      end
    end else if (i_shift) begin
      slot_reg[0] <= i_entry;
      for (int i = 1; i < DEPTH; i++) begin
        slot_reg[i] <= slot_reg[i-1];  // oldest falls off the end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read port; out of range reads zero
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rd_entry <= '0;
    end else if (int'(i_rd_idx) < DEPTH) begin
      o_rd_entry <= slot_reg[i_rd_idx];
    end else begin
      o_rd_entry <= '0;
    end
  end

endmodule : thl_log_mem

`default_nettype wire

// *** bench/thl_trip_monitor.sv ***
// checker for the trip logger: trip response, freeze, read timing, errors
// assumes bind onto thl_trip_logger, one clock, async low reset
`default_nettype none
module thl_trip_monitor #(
  parameter int MON_N = 18,
  parameter int MON_W = 16
) (
  input wire logic I_MCLK, // clock
  input wire logic I_RST_N, // reset, low
  input wire logic i_trip, // trip pulse
  input wire logic i_trip_clear, // trip clear
  input wire logic [7:0] i_trip_cfg, // config
  input wire logic i_rd, // read strobe
  input wire logic i_prog_active, // programming
  input wire logic O_STAGE_EN, // stage enable
  input wire logic O_TRIPPED, // tripped
  input wire logic O_FROZEN, // frozen
  input wire logic [MON_N*MON_W-1:0] O_MON, // monitors
  input wire logic O_RD_VALID, // read valid
  input wire logic [2:0] O_PROG_ERR // error code
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge I_MCLK);
  endclocking
  default disable iff (!I_RST_N);
  ////////////////////////////////
  // read answer comes two edges after the strobe
  sequence rd_req;
    i_rd;
  endsequence
  sequence rd_ans;
    ##2 O_RD_VALID;
  endsequence
  trip_off_a: assert property (i_trip |=> !O_STAGE_EN && O_TRIPPED)
    else $error("stage still on after trip");
  trip_hold_a: assert property (O_TRIPPED && !i_trip_clear |=> O_TRIPPED && !O_STAGE_EN)
    else $error("tripped state lost");
  freeze_set_a: assert property (i_trip && !i_trip_cfg[4] |=> O_FROZEN)
    else $error("no freeze on trip");
  mon_hold_a: assert property (O_FROZEN && !i_trip_cfg[4] |=> $stable(O_MON))
    else $error("monitor moved while frozen");
  no_freeze_a: assert property (i_trip_cfg[4] |=> !O_FROZEN)
    else $error("frozen with freeze off");
  clear_resume_a: assert property (i_trip_clear && !i_trip |=> O_STAGE_EN && !O_FROZEN)
    else $error("clear did not resume");
  read_lat_a: assert property (rd_req |-> rd_ans)
    else $error("read answer late");
  read_only_a: assert property (O_RD_VALID |-> $past(i_rd, 2))
    else $error("answer without read");
  err_sticky_a: assert property (O_PROG_ERR != 3'h0 |=> $stable(O_PROG_ERR))
    else $error("error code changed");
  err_idle_a: assert property (!i_prog_active && O_PROG_ERR == 3'h0 |=> O_PROG_ERR == 3'h0)
    else $error("error outside programming");
  err_range_a: assert property (O_PROG_ERR <= 3'h5)
    else $error("error code out of range");
endmodule : thl_trip_monitor

bind thl_trip_logger thl_trip_monitor #(.MON_N(MON_N), .MON_W(MON_W)) mon (
  .I_MCLK, .I_RST_N, .i_trip, .i_trip_clear, .i_trip_cfg, .i_rd, .i_prog_active,
  .O_STAGE_EN, .O_TRIPPED, .O_FROZEN, .O_MON, .O_RD_VALID, .O_PROG_ERR
);
`default_nettype wire

// *** bench/thl_host_model.sv ***
// serial host model: log reads and log-clear writes
// assumes tasks are called from a bench process aligned to clk
`default_nettype none
module thl_host_model (
  input wire logic clk, // system clock
  output logic rd, // read strobe
  output logic [3:0] rd_idx, // slot
  output logic clr_wr, // clear strobe
  output logic [7:0] clr_data // clear value
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {rd, rd_idx, clr_wr, clr_data} = '0;
  // idle lines show the inverse so a stale value is never reused
  task automatic read(input logic [3:0] idx);
    @(posedge clk) {rd, rd_idx} <= {1'h1, idx};
    @(posedge clk) {rd, rd_idx} <= {1'h0, ~idx};
  endtask : read
  // only 8'hff should wipe the log
  task automatic wr_clr(input logic [7:0] v);
    @(posedge clk) {clr_wr, clr_data} <= {1'h1, v};
    @(posedge clk) {clr_wr, clr_data} <= {1'h0, ~v};
  endtask : wr_clr
endmodule : thl_host_model
`default_nettype wire

// *** bench/thl_trip_logger_test.sv ***
// bench for the trip logger: log shift, freeze, reads, clear, errors
// assumes design files and host model compiled first
`default_nettype none
module thl_trip_logger_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_n, trip, has_sub, tclr, rd, cw, pact, ichk, stage_en, tripped, frozen, rv;
  logic [7:0] code, sub, cfg, cd, rc, rs;
  logic [15:0] date, tod, rdt, rtm;
  logic [3:0] idx, done, pres;
  logic [2:0] perr;
  logic [287:0] mon, mon_o, m1, m2;
  thl_pkg::thl_prog_type flt;
  logic [47:0] lg [10];
  logic [47:0] notes [$];
  int n_mismatch, checked;
  ////////////////////////////////
  thl_trip_logger dut (.I_MCLK(clk), .I_RST_N(rst_n), .i_trip(trip), .i_trip_code(code),
    .i_trip_has_sub(has_sub), .i_trip_sub(sub), .i_trip_clear(tclr), .i_date(date),
    .i_time(tod), .i_trip_cfg(cfg), .i_clr_wr(cw), .i_clr_data(cd), .i_rd(rd),
    .i_rd_idx(idx), .i_mon(mon), .i_prog_active(pact), .i_prog_flt(flt),
    .i_module_init_done_flag(done), .i_opt_present(pres), .i_init_check(ichk),
    .O_STAGE_EN(stage_en), .O_TRIPPED(tripped), .O_FROZEN(frozen), .O_MON(mon_o),
    .O_RD_VALID(rv), .O_RD_CODE(rc), .O_RD_SUB(rs), .O_RD_DATE(rdt), .O_RD_TIME(rtm),
    .O_PROG_ERR(perr));
  thl_host_model host (.clk(clk), .rd(rd), .rd_idx(idx), .clr_wr(cw), .clr_data(cd));
  initial begin
    clk = 1'h0;
    forever #10 clk = ~clk;
  end
  ////////////////////////////////
  task automatic check(input logic [47:0] seen, input logic [47:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic final_report();
    $display("compares %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : final_report
  task automatic do_reset();
    rst_n <= 1'h0;
    repeat (6) @(posedge clk);
    rst_n <= 1'h1;
    lg = '{default: '0};
  endtask : do_reset
  // back-to-back trips; the model log shifts exactly like the device
  task automatic trips(input int n);
    logic [47:0] e;
    for (int k = 0; k < n; k++) begin
      @(posedge clk);
      e = {8'($urandom), 8'($urandom), 16'($urandom), 16'($urandom)};
      {code, sub, date, tod} <= e;
      has_sub <= (k % 3 != 1);
      trip <= 1'h1;
      if (k % 3 == 1) e[39:32] = 8'h0;
      for (int j = 9; j > 0; j--) lg[j] = lg[j-1];
      lg[0] = e;
    end
    @(posedge clk) trip <= 1'h0;
  endtask : trips
  task automatic rd_chk(input logic [3:0] i);
    notes.push_back(i < 4'ha ? lg[i] : 48'h0);
    host.read(i);
  endtask : rd_chk
  task automatic clr_trip();
    @(posedge clk) tclr <= 1'h1;
    @(posedge clk) tclr <= 1'h0;
  endtask : clr_trip
  // oldest note is compared when the design answers a read
  always @(negedge clk) begin
    if (rv === 1'h1) begin
      if (notes.size() == 0) begin
        n_mismatch++;
        $display("[ERR] %0t read answer with no request", $time);
      end else check({rc, rs, rdt, rtm}, notes.pop_front());
    end
  end
  // hang guard, bounded
  initial begin
    repeat (5000) @(posedge clk);
    n_mismatch++;
    $display("[ERR] %0t run did not finish in time", $time);
    final_report();
  end
  ////////////////////////////////
  initial begin
    {trip, has_sub, tclr, pact, ichk, code, sub, date, tod, cfg, mon, flt, done, pres} = '0;
    void'($urandom(32'h90215f3b));
    m1 = {9{32'($urandom)}};
    m2 = ~m1;
    do_reset();
    @(posedge clk) mon <= m1;
    @(negedge clk);
    check(48'(stage_en), 48'h1);
    trips(12);
    @(posedge clk) mon <= m2;
    repeat (3) @(posedge clk);
    @(negedge clk);
    check(48'({stage_en, tripped, frozen, mon_o === m1}), 48'h7);
    for (int i = 0; i < 11; i++) rd_chk(4'(i));
    host.wr_clr(8'hfe);
    rd_chk(4'h9);
    host.wr_clr(8'hff);
    lg = '{default: '0};
    rd_chk(4'h0);
    clr_trip();
    repeat (2) @(posedge clk);
    @(negedge clk);
    check(48'({stage_en, tripped, frozen, mon_o === m2}), 48'h9);
    // freeze switched off: monitors keep following the live values
    @(posedge clk) cfg <= 8'h10;
    trips(1);
    @(posedge clk) mon <= m1;
    repeat (2) @(posedge clk);
    @(negedge clk);
    check(48'({tripped, frozen, mon_o === m1}), 48'h5);
    clr_trip();
    cfg <= 8'h0;
    // codes 1 to 4 each with every higher code's i_prog_flt fault also set, so the lowest code must win; code 5 alone
    for (int k = 0; k < 6; k++) begin
      do_reset();
      flt <= (k == 0 || k == 5) ? 4'h0 : 4'(4'hf >> (k - 1));
      {done, pres, ichk, pact} <= {(k == 5) ? 4'h7 : 4'hf, 4'hf, 2'h3};
      repeat (3) @(posedge clk);
      @(negedge clk);
      check(48'(perr), 48'(k));
    end
    for (int k = 0; k < 20 && notes.size() > 0; k++) @(posedge clk);
    if (notes.size() != 0) begin
      n_mismatch++;
      $display("[ERR] %0t reads left unanswered", $time);
    end
    final_report();
  end
endmodule : thl_trip_logger_test
`default_nettype wire
